// ### rtl/dpsba_host.sv
// Host controller for one port of the dual-port token latches
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Settle select and address before write pulse
// - Exactly one master among width-expanded parts
// - Deselect between successive token reads
// - Acquire by write zero, then read back
// - Write one to every latch at start
module dpsba_host
  import dpsba_pkg::*;
#(
  parameter logic IS_MASTER = 1'h1   // This port's part is the array master
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    cmd_valid,
  input  wire dpsba_pkg::dpsba_op_type cmd_op,
  input  wire logic [2:0]              cmd_index,
  output var  logic                    cmd_ready,
  output var  logic                    rsp_valid,
  output var  logic                    rsp_granted,
  output var  logic                    rsp_flag,
  output var  logic                    rsp_busy,
  output var  logic                    init_done,
  output var  logic                    master_select,
  output var  logic                    array_ce_n,
  output var  logic                    token_space_select_n,
  output var  logic                    oe_n,
  output var  logic                    rw_n,
  output var  logic                    byte_sel_n,
  output var  logic [13:0]             token_index_lines,
  output var  logic [15:0]             dq_out,
  output var  logic                    dq_oe,
  input  wire logic [15:0]             dq_in,
  input  wire logic                    busy_n_in
);
  import dpsba_pkg::*;

  typedef enum logic [2:0] {
    HS_INIT  = 3'h0,
    HS_IDLE  = 3'h1,
    HS_ISSUE = 3'h2,
    HS_WAIT  = 3'h3,
    HS_RESP  = 3'h4
  } dpsba_hs_type;

  dpsba_hs_type state, next_state;  // Sequencer state
  dpsba_op_type op;                 // Command in progress
  logic [2:0]   index;              // Token being worked
  logic         wr_phase;           // Current cycle is a write
  logic         wbit;               // Bit written this cycle
  logic         busy_acc;           // Conflict seen during command

  dpsba_cyc_if cyc ();               // Channel to pin engine

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      HS_INIT:  next_state = HS_ISSUE;
      HS_IDLE:  if (cmd_valid) next_state = HS_ISSUE;
      HS_ISSUE: next_state = HS_WAIT;
      HS_WAIT: begin
        if (cyc.done) begin
          if (!init_done) begin
            // Walk all latches, then open for commands
            next_state = (index == LAST_IDX) ? HS_IDLE : HS_ISSUE;
          end else if (op == OP_ACQUIRE && wr_phase) begin
            next_state = HS_ISSUE;
          end else begin
            next_state = HS_RESP;
          end
        end
      end
      HS_RESP:  next_state = HS_IDLE;
      default:  next_state = HS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= HS_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Cycle parameters: what the next pin cycle does
  always_ff @(posedge clk) begin
    if (rst) begin
      op       <= OP_POLL;
      index    <= 3'h0;
      wr_phase <= 1'h1;
      wbit     <= FREE_BIT;
    end else if (state == HS_INIT) begin
      index    <= 3'h0;
      wr_phase <= 1'h1;
      wbit     <= FREE_BIT;
    end else if (state == HS_IDLE && cmd_valid) begin
      op       <= cmd_op;
      index    <= cmd_index;
      wr_phase <= (cmd_op == OP_ACQUIRE) || (cmd_op == OP_RELEASE);
      // Claim writes zero, release writes one
      wbit     <= (cmd_op == OP_ACQUIRE) ? CLAIM_BIT : FREE_BIT;
    end else if (state == HS_WAIT && cyc.done) begin
      if (!init_done) begin
        index <= index + 3'h1;
      end else if (op == OP_ACQUIRE && wr_phase) begin
        wr_phase <= 1'h0;  // Read back only after the claim write
      end
    end
  end

  // Drive the pin engine request
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc.req   <= 1'h0;
      cyc.wr    <= 1'h0;
      cyc.index <= 3'h0;
      cyc.wbit  <= FREE_BIT;
    end else begin
      cyc.req   <= (next_state == HS_ISSUE);
      cyc.wr    <= (next_state == HS_ISSUE) ? next_wr() : cyc.wr;
      cyc.index <= (state == HS_IDLE && cmd_valid) ? cmd_index
                 : (state == HS_WAIT && !init_done) ? index + 3'h1 : index;
      cyc.wbit  <= (state == HS_IDLE && cmd_valid)
                 ? ((cmd_op == OP_ACQUIRE) ? CLAIM_BIT : FREE_BIT) : wbit;
    end
  end

  // Direction of the cycle about to be issued
  function automatic logic next_wr();
    logic w;
    w = wr_phase;
    if (state == HS_IDLE) begin
      w = (cmd_op == OP_ACQUIRE) || (cmd_op == OP_RELEASE);
    end else if (state == HS_WAIT && init_done && op == OP_ACQUIRE && wr_phase) begin
      w = 1'h0;
    end else if (state == HS_INIT || !init_done) begin
      w = 1'h1;
    end
    return w;
  endfunction

  // Initialisation complete flag
  always_ff @(posedge clk) begin
    if (rst) begin
      init_done <= 1'h0;
    end else if (state == HS_WAIT && cyc.done && !init_done && index == LAST_IDX) begin
      init_done <= 1'h1;
    end
  end

  // ----------------------------------------
  // Handshake and results
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ready   <= 1'h0;
      rsp_valid   <= 1'h0;
      rsp_granted <= 1'h0;
      rsp_flag    <= 1'h1;
      rsp_busy    <= 1'h0;
      busy_acc    <= 1'h0;
    end else begin
      cmd_ready <= (next_state == HS_IDLE);
      rsp_valid <= (next_state == HS_RESP);
      if (state == HS_IDLE) begin
        busy_acc <= 1'h0;
      end else if (state == HS_WAIT && cyc.done) begin
        busy_acc <= busy_acc | cyc.busy_seen;
      end
      if (next_state == HS_RESP) begin
        // Granted only when the read-back shows all zeros
        rsp_granted <= (op == OP_ACQUIRE) && (cyc.rdata == 16'h0000);
        rsp_flag    <= wr_phase ? wbit : cyc.rdata[0];
        rsp_busy    <= busy_acc | cyc.busy_seen;
      end
    end
  end

  // Fixed configuration pins: array stays deselected
  always_ff @(posedge clk) begin
    if (rst) begin
      master_select <= 1'h0;
      array_ce_n    <= 1'h1;
    end else begin
      master_select <= IS_MASTER;
      array_ce_n    <= 1'h1;
    end
  end

  // ----------------------------------------
  // Pin engine
  // ----------------------------------------
  dpsba_pin_cycle u_pin (
    .clk        (clk),
    .rst        (rst),
    .cyc        (cyc.pins),
    .sel_n      (token_space_select_n),
    .oe_n       (oe_n),
    .rw_n       (rw_n),
    .byte_sel_n (byte_sel_n),
    .addr       (token_index_lines),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dq_in      (dq_in),
    .busy_n_in  (busy_n_in)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [3:0] init_writes;  // Free writes issued before init_done
  always_ff @(posedge clk) begin
    if (rst) begin
      init_writes <= 4'h0;
    end else if (!init_done && cyc.req && cyc.wr && cyc.wbit) begin
      init_writes <= init_writes + 4'h1;
    end
  end

  init_all_a: assert property (@(posedge clk) disable iff (rst)
    $rose(init_done) |-> init_writes == 4'h8)
    else $error("initialisation did not free all eight latches");
  init_first_a: assert property (@(posedge clk) disable iff (rst)
    cmd_ready |-> init_done)
    else $error("command accepted before initialisation");
  claim_then_read_a: assert property (@(posedge clk) disable iff (rst)
    (cyc.req && cyc.wr && !cyc.wbit) |-> ##[1:60] (cyc.req && !cyc.wr))
    else $error("claim write not followed by read-back");
  grant_value_a: assert property (@(posedge clk) disable iff (rst)
    (rsp_valid && rsp_granted) |-> !rsp_flag)
    else $error("grant reported with flag one");
  single_master_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> master_select == IS_MASTER)
    else $error("master select not as configured");

  acq_won_c:  cover property (@(posedge clk) disable iff (rst) rsp_valid && rsp_granted);
  acq_lost_c: cover property (@(posedge clk) disable iff (rst)
    rsp_valid && op == OP_ACQUIRE && !rsp_granted);
  release_c:  cover property (@(posedge clk) disable iff (rst) rsp_valid && op == OP_RELEASE);
endmodule
`default_nettype wire

// ### common/dpsba_pkg.sv
// Shared constants and types for the token-latch host controller
package dpsba_pkg;
  // ----------------------------------------
  // Port geometry
  // ----------------------------------------
  localparam int         ADDR_W    = 14;      // Port address lines
  localparam int         DATA_W    = 16;      // Port data lines
  localparam int         IDX_W     = 3;       // Token index lines
  localparam logic [2:0] LAST_IDX  = 3'h7;    // Eighth token latch
  localparam logic       FREE_BIT  = 1'h1;    // Token free value
  localparam logic       CLAIM_BIT = 1'h0;    // Token request value
  // ----------------------------------------
  // Timing, in ns and in 5 ns cycles
  // ----------------------------------------
  localparam int         CLK_NS      = 5;     // Clock period
  localparam int         T_SETTLE_NS = 15;    // Select/address before write pulse
  localparam int         T_PULSE_NS  = 25;    // Write pulse width
  localparam int         T_ACCESS_NS = 25;    // Read access time
  localparam int         T_GAP_NS    = 10;    // Deselect time between cycles
  localparam int         SYNC_CYC    = 2;     // Input synchroniser depth
  localparam logic [3:0] SETTLE_CYC  = 4'((T_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC   = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACCESS_CYC  = 4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [3:0] GAP_CYC     = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_ACQUIRE = 2'h0,
    OP_RELEASE = 2'h1,
    OP_POLL    = 2'h2
  } dpsba_op_type;
endpackage

// ### common/dpsba_cyc_if.sv
// Cycle request channel between command sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none
interface dpsba_cyc_if;
  logic        req;        // One-cycle start pulse
  logic        wr;         // Write cycle when high
  logic [2:0]  index;      // Token latch index
  logic        wbit;       // Value for data bit zero
  logic        done;       // One-cycle completion pulse
  logic [15:0] rdata;      // Captured read word
  logic        busy_seen;  // Conflict flag low before write pulse
  modport ctrl (output req, wr, index, wbit, input done, rdata, busy_seen);
  modport pins (input req, wr, index, wbit, output done, rdata, busy_seen);
endinterface
`default_nettype wire

// ### rtl/dpsba_pin_cycle.sv
// Pin engine: one timed read or write cycle on the token space
`timescale 1ns/1ps
`default_nettype none
module dpsba_pin_cycle
  import dpsba_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  dpsba_cyc_if.pins              cyc,
  output var  logic              sel_n,
  output var  logic              oe_n,
  output var  logic              rw_n,
  output var  logic              byte_sel_n,
  output var  logic [ADDR_W-1:0] addr,
  output var  logic [DATA_W-1:0] dq_out,
  output var  logic              dq_oe,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              busy_n_in
);
  typedef enum logic [1:0] {
    PC_IDLE  = 2'h0,
    PC_SETUP = 2'h1,
    PC_PULSE = 2'h2,
    PC_GAP   = 2'h3
  } dpsba_pc_type;

  dpsba_pc_type      state, next_state;   // Cycle phase
  logic [3:0]        cnt, next_cnt;       // Phase countdown
  logic              wr;                  // Latched direction
  logic [2:0]        index;               // Latched index
  logic              wbit;                // Latched write bit
  logic [DATA_W-1:0] dq_s1, dq_s2;        // Data synchroniser
  logic              busy_s1, busy_s2;    // Conflict flag synchroniser
  logic              active;              // Select held from the next clock edge

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      PC_IDLE: begin
        if (cyc.req) begin
          next_state = PC_SETUP;
          next_cnt   = SETTLE_CYC - 4'h1;
        end
      end
      PC_SETUP: begin
        // Address and select settle before any pulse
        if (cnt == 4'h0) begin
          next_state = PC_PULSE;
          next_cnt   = (wr ? PULSE_CYC : ACCESS_CYC) - 4'h1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      PC_PULSE: begin
        if (cnt == 4'h0) begin
          next_state = PC_GAP;
          next_cnt   = GAP_CYC - 4'h1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      PC_GAP: begin
        if (cnt == 4'h0) begin
          next_state = PC_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PC_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Request latch
  always_ff @(posedge clk) begin
    if (rst) begin
      wr    <= 1'h0;
      index <= 3'h0;
      wbit  <= 1'h1;
    end else if (state == PC_IDLE && cyc.req) begin
      wr    <= cyc.wr;
      index <= cyc.index;
      wbit  <= cyc.wbit;
    end
  end

  // ----------------------------------------
  // Pin drive, registered from next phase
  // ----------------------------------------
  assign active = (next_state == PC_SETUP) || (next_state == PC_PULSE);

  // Select drops in the gap, so each read relatches
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_n      <= 1'h1;
      oe_n       <= 1'h1;
      rw_n       <= 1'h1;
      byte_sel_n <= 1'h1;
      dq_oe      <= 1'h0;
      addr       <= '0;
      dq_out     <= '0;
    end else begin
      sel_n      <= !active;
      byte_sel_n <= !active;
      oe_n       <= !(next_state == PC_PULSE && !wr);
      rw_n       <= !(next_state == PC_PULSE && wr);
      if (state == PC_IDLE && cyc.req) begin
        // Index and data launch with select
        dq_oe  <= cyc.wr;
        addr   <= {{(ADDR_W-IDX_W){1'h0}}, cyc.index};
        dq_out <= {{(DATA_W-1){1'h0}}, cyc.wbit};
      end else begin
        dq_oe  <= active && wr;
        addr   <= {{(ADDR_W-IDX_W){1'h0}}, index};
        dq_out <= {{(DATA_W-1){1'h0}}, wbit};
      end
    end
  end

  // Two-stage input synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_s1   <= '0;
      dq_s2   <= '0;
      busy_s1 <= 1'h1;
      busy_s2 <= 1'h1;
    end else begin
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
      busy_s1 <= busy_n_in;
      busy_s2 <= busy_s1;
    end
  end

  // Results and completion pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc.rdata     <= '0;
      cyc.busy_seen <= 1'h0;
      cyc.done      <= 1'h0;
    end else begin
      cyc.done <= (state == PC_GAP) && (cnt == 4'h0);
      if (state == PC_PULSE && cnt == 4'h0 && !wr) begin
        cyc.rdata <= dq_s2;
      end
      if (state == PC_SETUP && cnt == 4'h0) begin
        cyc.busy_seen <= wr && !busy_s2;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [3:0] sel_low;  // Cycles select has been low
  always_ff @(posedge clk) begin
    if (rst || sel_n) begin
      sel_low <= 4'h0;
    end else if (sel_low != 4'hF) begin
      sel_low <= sel_low + 4'h1;
    end
  end

  settle_before_write_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rw_n) |-> (sel_low == SETTLE_CYC) && oe_n)
    else $error("write pulse began before select settled");
  pulse_width_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rw_n) |-> !rw_n[*5] ##1 rw_n)
    else $error("write pulse width wrong");
  read_release_a: assert property (@(posedge clk) disable iff (rst)
    $rose(oe_n) |-> sel_n ##1 sel_n)
    else $error("read not followed by deselect");
endmodule
`default_nettype wire

// ### tb/dpsba_dev_model.sv
// Behavioural token-latch device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module dpsba_dev_model
  import dpsba_pkg::*;
(
  input  wire logic        l_sel_n,
  input  wire logic        l_oe_n,
  input  wire logic        l_rw_n,
  input  wire logic [13:0] l_addr,
  input  wire logic [15:0] l_d,
  output var  logic [15:0] l_q,
  input  wire logic        r_sel_n,
  input  wire logic        r_oe_n,
  input  wire logic        r_rw_n,
  input  wire logic [2:0]  r_idx,
  input  wire logic        r_d0,
  output var  logic [15:0] r_q,
  input  wire logic        slow,
  input  wire logic        busy_cmd,
  output var  logic        busy_n
);
  // ----------------------------------------
  // Latch state, not cleared at power-up
  // ----------------------------------------
  logic [7:0]  req_l = 8'h00;         // Left request latches
  logic [7:0]  req_r = 8'hFF;         // Right request latches
  logic [1:0]  own [8];               // 0 free, 1 left, 2 right
  logic [15:0] out_l = 16'h0000;      // Left output register
  logic [15:0] out_r = 16'h0000;      // Right output register
  logic        vis_l = 1'b0;          // Left read data on the bus
  wire  logic  rd_l  = !l_sel_n && !l_oe_n;
  wire  logic  rd_r  = !r_sel_n && !r_oe_n;
  initial foreach (own[i]) own[i] = 2'h1;
  // ----------------------------------------
  // Writes: level sensitive, left then right
  // ----------------------------------------
  always @(l_sel_n, l_rw_n, l_addr, l_d, r_sel_n, r_rw_n, r_idx, r_d0) begin
    // Left writes dropped while its conflict flag is low
    if (!l_sel_n && !l_rw_n && busy_n) req_l[l_addr[2:0]] = l_d[0];
    if (!r_sel_n && !r_rw_n) req_r[r_idx] = r_d0;
    for (int i = 0; i < 8; i++) begin
      if (own[i] == 2'h1 && req_l[i]) own[i] = req_r[i] ? 2'h0 : 2'h2;
      if (own[i] == 2'h2 && req_r[i]) own[i] = req_l[i] ? 2'h0 : 2'h1;
      if (own[i] == 2'h0) own[i] = !req_l[i] ? 2'h1 : (!req_r[i] ? 2'h2 : 2'h0);
    end
  end
  // ----------------------------------------
  // Reads: captured as select and enable go low
  // ----------------------------------------
  always @(posedge rd_l) begin
    out_l = {16{own[l_addr[2:0]] != 2'h1}};
    vis_l = 1'b0;
    #(slow ? 20 : 2);
    vis_l = rd_l;
  end
  always @(negedge rd_l) vis_l = 1'b0;
  always @(posedge rd_r) out_r = {16{own[r_idx] != 2'h2}};
  // Released bus shows the inverse of the last word; tokens gate nothing
  assign l_q = (rd_l && vis_l) ? out_l : ~out_l;
  assign r_q = rd_r ? out_r : ~out_r;
  // Master drives the conflict flag
  assign busy_n = !busy_cmd;
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the token-latch host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpsba_pkg::*;
  logic         clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
  dpsba_op_type cmd_op = OP_POLL;
  logic [2:0]   cmd_index = 3'h0, r_idx = 3'h0;
  logic         cmd_ready, rsp_valid, rsp_granted, rsp_flag, rsp_busy, init_done;
  logic         master_select, array_ce_n, sel_n, oe_n, rw_n, bsel_n, dq_oe, busy_n;
  logic [13:0]  addr;
  logic [15:0]  dq_out, dq_in, r_q;
  logic         r_sel_n = 1'b1, r_oe_n = 1'b1, r_rw_n = 1'b1, r_d0 = 1'b0;
  logic         slow = 1'b0, busy_cmd = 1'b0;
  int           bad_count = 0, checked = 0;
  logic [1:0]   own [8];            // Expected owner: 0 free, 1 host, 2 far port
  logic [7:0]   rl, rr;             // Expected request latches
  always #2.5 clk = ~clk;
  dpsba_host i_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_index(cmd_index), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_granted(rsp_granted), .rsp_flag(rsp_flag), .rsp_busy(rsp_busy),
    .init_done(init_done), .master_select(master_select), .array_ce_n(array_ce_n),
    .token_space_select_n(sel_n), .oe_n(oe_n), .rw_n(rw_n), .byte_sel_n(bsel_n),
    .token_index_lines(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .busy_n_in(busy_n));
  dpsba_dev_model i_dev (.l_sel_n(sel_n), .l_oe_n(oe_n), .l_rw_n(rw_n), .l_addr(addr),
    .l_d(dq_oe ? dq_out : ~dq_out), .l_q(dq_in), .r_sel_n(r_sel_n), .r_oe_n(r_oe_n), .r_rw_n(r_rw_n),
    .r_idx(r_idx), .r_d0(r_d0), .r_q(r_q), .slow(slow), .busy_cmd(busy_cmd),
    .busy_n(busy_n));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for a level, sampled at falling edges
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 600) begin
        bad_count++;
        $display("wrong value at %0t: wait ran out", $time);
        report_and_stop;
      end
    end
  endtask
  // Expected owner after a latch write
  function automatic logic [1:0] upd(input logic [1:0] o, input logic l, input logic r);
    if (o == 2'h1 && l) return r ? 2'h0 : 2'h2;
    if (o == 2'h2 && r) return l ? 2'h0 : 2'h1;
    if (o != 2'h0) return o;
    return !l ? 2'h1 : (!r ? 2'h2 : 2'h0);
  endfunction
  // ----------------------------------------
  // Host commands and far-port cycles
  // ----------------------------------------
  task automatic left_op(input logic [1:0] op, input logic [2:0] idx);
    wait_hi(cmd_ready);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= dpsba_op_type'(op);
    cmd_index <= idx;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    wait_hi(rsp_valid);
    if (op == 2'h0 && !busy_cmd) rl[idx] = 1'b0;
    if (op == 2'h1 && !busy_cmd) rl[idx] = 1'b1;
    own[idx] = upd(own[idx], rl[idx], rr[idx]);
    if (op == 2'h1) check(16'(rsp_flag), 16'h0001);
    else check(16'(rsp_flag), 16'(own[idx] != 2'h1));
    if (op == 2'h0) check(16'(rsp_granted), 16'(own[idx] == 2'h1));
  endtask
  task automatic right_op(input logic wr, input logic [2:0] idx, input logic b);
    @(posedge clk);
    r_sel_n <= 1'b0;
    r_rw_n  <= !wr;
    r_oe_n  <= wr;
    r_idx   <= idx;
    r_d0    <= b;
    repeat (2) @(posedge clk);
    if (wr) begin
      rr[idx] = b;
      own[idx] = upd(own[idx], rl[idx], rr[idx]);
    end
    else check(r_q, {16{own[idx] != 2'h2}});
    r_sel_n <= 1'b1;
    r_rw_n  <= 1'b1;
    r_oe_n  <= 1'b1;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h76B1));
    foreach (own[i]) own[i] = 2'h1;
    rl = 8'h00;
    rr = 8'hFF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(16'({cmd_ready, master_select, dq_oe, bsel_n, sel_n, rw_n, oe_n, array_ce_n}), 16'h001F);
    @(posedge clk);
    rst <= 1'b0;
    wait_hi(init_done);
    for (int i = 0; i < 8; i++) begin
      rl[i] = 1'b1;
      own[i] = upd(own[i], rl[i], rr[i]);
    end
    check(16'({master_select, array_ce_n}), 16'h0003);
    for (int i = 0; i < 8; i++) begin
      left_op(2'h2, 3'(i));
      right_op(1'b0, 3'(i), 1'b0);
    end
    $display("test init done");
    // Hand-over through a pending request on one latch
    left_op(2'h0, 3'h5);
    right_op(1'b1, 3'h5, 1'b0);
    right_op(1'b0, 3'h5, 1'b0);
    left_op(2'h2, 3'h5);
    left_op(2'h1, 3'h5);
    left_op(2'h2, 3'h5);
    left_op(2'h0, 3'h5);
    right_op(1'b1, 3'h5, 1'b1);
    left_op(2'h3, 3'h5);
    left_op(2'h1, 3'h5);
    $display("test hand-over done");
    // Far port claims first while the host acquire is under way
    fork
      left_op(2'h0, 3'h3);
      right_op(1'b1, 3'h3, 1'b0);
    join
    right_op(1'b1, 3'h3, 1'b1);
    left_op(2'h1, 3'h3);
    $display("test race done");
    // Conflict flag low during a write is reported
    busy_cmd <= 1'b1;
    left_op(2'h0, 3'h0);
    check(16'(rsp_busy), 16'h0001);
    busy_cmd <= 1'b0;
    left_op(2'h1, 3'h0);
    check(16'(rsp_busy), 16'h0000);
    $display("test conflict done");
    // Random mix from both ports, prompt and slow device
    for (int k = 0; k < 60; k++) begin
      slow <= 1'($urandom % 2);
      if ($urandom % 3 == 0) right_op(1'($urandom), 3'($urandom), 1'($urandom));
      else left_op(2'($urandom), 3'($urandom));
    end
    $display("test random done");
    report_and_stop;
  end
endmodule
`default_nettype wire
